/* File: pkg/scc_regs.svh */
// Offsets, field positions, reset values and timing counts of the core
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
`define SCC_BANK_PORT    4'hd
`define SCC_BANK_BIT     2
`define SCC_BANK_RST     1'b0
`define SCC_PC_RST       12'h000
`define SCC_COMMON_TOP   12'h7ff
`define SCC_RP_STEP      8'h04
`define SCC_PTR_RST      8'h00
`define SCC_FLAGS_RST    4'h0
`define SCC_FLAG_GATE    0
`define SCC_FLAG_JUMP    1
`define SCC_FLAG_BORROW  3
`define SCC_MC_CLKS      2
`endif

/* File: pkg/scc_pkg.sv */
// Types, states and opcode encodings of the stack CPU core
package scc_pkg;
	typedef enum logic [2:0] {
		st_exec  = 3'h0,
		st_oper  = 3'h1,
		st_step2 = 3'h3,
		st_rpush = 3'h2,
		st_rpop  = 3'h6,
		st_tail  = 3'h7
	} scc_state_type;

	localparam logic [7:0] op_nop      = 8'h00;
	localparam logic [7:0] op_add      = 8'h01;
	localparam logic [7:0] op_addc     = 8'h02;
	localparam logic [7:0] op_sub      = 8'h03;
	localparam logic [7:0] op_and      = 8'h04;
	localparam logic [7:0] op_or       = 8'h05;
	localparam logic [7:0] op_xor      = 8'h06;
	localparam logic [7:0] op_rol      = 8'h07;
	localparam logic [7:0] op_ror      = 8'h08;
	localparam logic [7:0] op_drop     = 8'h09;
	localparam logic [7:0] op_dup      = 8'h0a;
	localparam logic [7:0] op_unmask   = 8'h10;
	localparam logic [7:0] op_mask     = 8'h11;
	localparam logic [7:0] op_set_bcf  = 8'h12;
	localparam logic [7:0] op_tog_bf   = 8'h13;
	localparam logic [7:0] op_flag_wr  = 8'h14;
	localparam logic [7:0] op_flag_rd  = 8'h15;
	localparam logic [7:0] op_ret      = 8'h16;
	localparam logic [7:0] op_svc_ret  = 8'h17;
	localparam logic [7:0] op_sleep    = 8'h18;
	localparam logic [7:0] op_to_ret   = 8'h19;
	localparam logic [7:0] op_from_ret = 8'h1a;

	localparam logic [3:0] grp_lit   = 4'h2;
	localparam logic [3:0] grp_ptr   = 4'h3;
	localparam logic [3:0] grp_ldptr = 4'h4;
	localparam logic [3:0] grp_in    = 4'h5;
	localparam logic [3:0] grp_out   = 4'h6;
	localparam logic [3:0] grp_table = 4'h7;
	localparam logic [3:0] grp_bra   = 4'hc;
	localparam logic [3:0] grp_jmp   = 4'hd;
	localparam logic [3:0] grp_call  = 4'he;
	localparam logic [1:0] grp_svj   = 2'h2;

	localparam logic [2:0] px_fetch     = 3'h0;
	localparam logic [2:0] px_fetch_inc = 3'h1;
	localparam logic [2:0] px_fetch_dec = 3'h2;
	localparam logic [2:0] px_store     = 3'h3;
	localparam logic [2:0] px_store_inc = 3'h4;
	localparam logic [2:0] px_store_dec = 3'h5;

	typedef struct packed {
		logic [3:0] addr;
		logic [3:0] wdata;
		logic       rd;
		logic       wr;
	} scc_io_req_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [3:0] wdata;
		logic       we;
	} scc_ram_req_type;

	typedef struct packed {
		logic [255:0][3:0] mem;
		logic [3:0]        rdata;
	} scc_ram_state_type;

	typedef struct packed {
		scc_state_type st;
		logic          phase;
		logic [11:0]   fetch_counter;
		logic [7:0]    ir;
		logic [7:0]    imm;
		logic [3:0]    top_item_accum;
		logic [7:0]    expr_stack_ptr;
		logic [7:0]    return_stack_ptr;
		logic [7:0]    ram_pointer_one;
		logic [7:0]    ram_pointer_two;
		logic [3:0]    flag_nibble;
		logic          rom_bank_select;
		logic [11:0]   rdata;
		logic [1:0]    idx;
	} scc_core_state_type;
endpackage : scc_pkg

/* File: verilog/scc_ram.sv */
// Data RAM of the core, registered read data
`timescale 1ns/1ps
module scc_ram (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_sys_rst,
	// Access port
	input  wire scc_pkg::scc_ram_req_type i_req,
	output logic [3:0]                    o_rdata
);
	import scc_pkg::*;

	scc_ram_state_type q;
	scc_ram_state_type d;

	// Address is held a full machine cycle, so data is valid on phase 1
	always_comb begin
		d = q;
		d.rdata = q.mem[i_req.addr];
		if (i_req.we) begin
			d.mem[i_req.addr] = i_req.wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_rdata = q.rdata;
endmodule : scc_ram

/* File: verilog/scc_core.sv */
// Stack CPU core: fetch counter, banking, stacks, pointers, accumulator, flags
// Summary of operation
// - Twelve-bit fetch counter addresses program ROM, one bank spans 4 Kbytes.
// - Extra 2 Kbyte ROM region reachable only via the bank switch.
// - Lowest 512 bytes hold short vector jump and interrupt entry targets.
// - Software writes the bank number; execution starts from bank 0.
// - Addresses 000h to 7FFh ignore the bank; only upper half is banked.
// - 256 RAM nibbles, each reachable through any of four 8-bit pointers.
// - Arithmetic, I/O and memory operations use the expression stack.
// - Return stack holds 12-bit entries, exchangeable with expression items.
// - Fetch counter increments on each byte fetched, loads target on branch or call.
// - Table lookup reads an 8-bit ROM constant over the fetch path.
// - Expression pointer pre-increments on push; pop moves second item first.
// - Return pointer moves in steps of 4, one nibble left unwritten.
// - Pointer one and two fetch and store, with pre-inc and post-dec forms.
// - Accumulator loads from ALU, ROM, RAM or the I/O bus.
// - Flag nibble changed by ALU and by dedicated flag instructions.
// - Borrow records carry, is fifth bit in shifts, kept by booleans.
// - Conditional branch jumps only with jump flag set; ALU updates it.
// - Gate clears on reset or mask, sets on unmask, service return or sleep.
// - Four-bit ALU combines top two items into the accumulator.
// - Separate instruction, memory and I/O buses allow prefetch.
// - Machine cycle is two clocks; instructions take one to five cycles.
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_core (
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_sys_rst,
	// Instruction bus
	output logic [12:0]                  o_rom_addr,
	input  wire logic [7:0]              i_rom_data,
	// I/O bus
	output scc_pkg::scc_io_req_type      o_io_req,
	input  wire logic [3:0]              i_io_data,
	// Interrupt controller
	input  wire logic                    i_int_req,
	input  wire logic [5:0]              i_int_vector,
	output logic                         o_int_ack,
	output logic                         o_svc_done,
	output logic                         o_sleep_req,
	// Status
	output logic [3:0]                   o_flag_nibble,
	output logic [3:0]                   o_top_item_accum
);
	import scc_pkg::*;

	scc_core_state_type q;
	scc_core_state_type d;
	scc_ram_req_type    ram;
	scc_io_req_type     io;
	logic [3:0]         rd;
	logic               ce;
	logic               fin;
	logic               int_ack;
	logic               svc_done;
	logic               sleep_req;
	logic [11:0]        rom_lin;

	// Returns {jump, borrow, result}
	function automatic logic [5:0] alu_calc(
		input logic [7:0] op,
		input logic [3:0] t,
		input logic [3:0] s,
		input logic       c
	);
		logic [4:0] w;
		logic       is_logic;
		w = 5'h00;
		is_logic = 1'b0;
		case (op)
			op_add:  w = {1'b0, s} + {1'b0, t};
			op_addc: w = {1'b0, s} + {1'b0, t} + {4'h0, c};
			op_sub:  w = {1'b0, s} - {1'b0, t};
			op_and: begin
				w = {c, s & t};
				is_logic = 1'b1;
			end
			op_or: begin
				w = {c, s | t};
				is_logic = 1'b1;
			end
			op_xor: begin
				w = {c, s ^ t};
				is_logic = 1'b1;
			end
			op_rol:  w = {t, c};
			op_ror:  w = {t[0], c, t[3:1]};
			default: w = {c, t};
		endcase
		// Jump flag: carry for arithmetic and shifts, zero for booleans
		alu_calc = {is_logic ? (w[3:0] == 4'h0) : w[4], w};
	endfunction : alu_calc

	scc_ram u_ram (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_req     (ram),
		.o_rdata   (rd)
	);

	// Work is committed on the second clock of each machine cycle
	assign ce = (q.phase == 1'((`SCC_MC_CLKS) - 1));

	always_comb begin
		logic [5:0] alu;
		logic [7:0] ptr;
		logic [7:0] base;
		alu = 6'h00;
		ptr = q.ir[3] ? q.ram_pointer_two : q.ram_pointer_one;
		base = 8'h00;
		d = q;
		fin = 1'b0;
		int_ack = 1'b0;
		svc_done = 1'b0;
		sleep_req = 1'b0;
		ram.addr = q.expr_stack_ptr;
		ram.wdata = q.top_item_accum;
		ram.we = 1'b0;
		io.addr = q.ir[3:0];
		io.wdata = q.top_item_accum;
		io.rd = 1'b0;
		io.wr = 1'b0;
		d.phase = ce ? 1'b0 : 1'b1;
		unique case (q.st)
			st_exec: begin
				if (q.ir[7:6] == grp_svj) begin
					d.rdata = q.fetch_counter;
					d.fetch_counter = {3'h0, q.ir[5:0], 3'h0};
					d.ir = op_nop;
					d.idx = 2'h0;
					d.st = st_rpush;
				end else begin
					case (q.ir[7:4])
						4'h0, 4'h1: begin
							fin = 1'b1;
							case (q.ir)
								op_add, op_addc, op_sub, op_and, op_or,
								op_xor: begin
									alu = alu_calc(q.ir, q.top_item_accum, rd,
										q.flag_nibble[`SCC_FLAG_BORROW]);
									d.top_item_accum = alu[3:0];
									d.flag_nibble[`SCC_FLAG_BORROW] = alu[4];
									d.flag_nibble[`SCC_FLAG_JUMP] = alu[5];
									d.expr_stack_ptr = q.expr_stack_ptr - 8'h01;
								end
								op_rol, op_ror: begin
									alu = alu_calc(q.ir, q.top_item_accum,
										q.top_item_accum,
										q.flag_nibble[`SCC_FLAG_BORROW]);
									d.top_item_accum = alu[3:0];
									d.flag_nibble[`SCC_FLAG_BORROW] = alu[4];
									d.flag_nibble[`SCC_FLAG_JUMP] = alu[5];
								end
								op_drop, op_flag_wr: begin
									// Pop: second item moves up before the decrement
									d.top_item_accum = rd;
									d.expr_stack_ptr = q.expr_stack_ptr - 8'h01;
									if (q.ir == op_flag_wr) begin
										d.flag_nibble = q.top_item_accum;
										// Spare bit stays zero
										d.flag_nibble[2] = 1'b0;
									end
								end
								op_dup, op_flag_rd: begin
									ram.addr = q.expr_stack_ptr + 8'h01;
									ram.we = 1'b1;
									d.expr_stack_ptr = q.expr_stack_ptr + 8'h01;
									if (q.ir == op_flag_rd) begin
										d.top_item_accum = q.flag_nibble;
									end
								end
								op_unmask: d.flag_nibble[`SCC_FLAG_GATE] = 1'b1;
								op_mask:   d.flag_nibble[`SCC_FLAG_GATE] = 1'b0;
								op_sleep: begin
									d.flag_nibble[`SCC_FLAG_GATE] = 1'b1;
									sleep_req = 1'b1;
								end
								op_set_bcf: begin
									d.flag_nibble[`SCC_FLAG_BORROW] = 1'b1;
									d.flag_nibble[`SCC_FLAG_JUMP] = 1'b1;
								end
								op_tog_bf: d.flag_nibble[`SCC_FLAG_JUMP] =
									~q.flag_nibble[`SCC_FLAG_JUMP];
								op_ret, op_svc_ret, op_from_ret: begin
									fin = 1'b0;
									d.idx = 2'h0;
									d.st = st_rpop;
								end
								op_to_ret: begin
									fin = 1'b0;
									d.rdata = {8'h00, q.top_item_accum};
									d.top_item_accum = rd;
									d.expr_stack_ptr = q.expr_stack_ptr - 8'h01;
									d.idx = 2'h0;
									d.st = st_rpush;
								end
								default: ;
							endcase
						end
						grp_lit, grp_in: begin
							ram.addr = q.expr_stack_ptr + 8'h01;
							ram.we = 1'b1;
							d.expr_stack_ptr = q.expr_stack_ptr + 8'h01;
							d.top_item_accum = q.ir[3:0];
							if (q.ir[7:4] == grp_in) begin
								if (q.ir[3:0] == `SCC_BANK_PORT) begin
									d.top_item_accum = 4'h0;
									d.top_item_accum[`SCC_BANK_BIT] =
										q.rom_bank_select;
								end else begin
									io.rd = 1'b1;
									d.top_item_accum = i_io_data;
								end
							end
							fin = 1'b1;
						end
						grp_out: begin
							if (q.ir[3:0] == `SCC_BANK_PORT) begin
								d.rom_bank_select =
									q.top_item_accum[`SCC_BANK_BIT];
							end else begin
								io.wr = 1'b1;
							end
							d.top_item_accum = rd;
							d.expr_stack_ptr = q.expr_stack_ptr - 8'h01;
							fin = 1'b1;
						end
						grp_ptr: begin
							d.st = st_step2;
							case (q.ir[2:0])
								px_fetch, px_fetch_inc, px_fetch_dec: begin
									ram.addr = q.expr_stack_ptr + 8'h01;
									ram.we = 1'b1;
									d.expr_stack_ptr = q.expr_stack_ptr + 8'h01;
									if (q.ir[2:0] == px_fetch_inc) begin
										base = ptr + 8'h01;
									end else begin
										base = ptr;
									end
								end
								px_store, px_store_inc, px_store_dec: begin
									ram.addr = (q.ir[2:0] == px_store_inc) ?
										ptr + 8'h01 : ptr;
									ram.we = 1'b1;
									base = (q.ir[2:0] == px_store_dec) ?
										ptr - 8'h01 : ram.addr;
								end
								default: begin
									base = ptr;
									d.st = st_exec;
									fin = 1'b1;
								end
							endcase
							if (q.ir[3]) d.ram_pointer_two = base;
							else d.ram_pointer_one = base;
						end
						grp_ldptr, grp_table, grp_bra, grp_jmp, grp_call: begin
							d.imm = i_rom_data;
							d.fetch_counter = q.fetch_counter + 12'h001;
							d.st = st_oper;
						end
						default: fin = 1'b1;
					endcase
				end
			end
			st_step2: begin
				fin = 1'b1;
				if (q.ir[2:0] <= px_fetch_dec) begin
					ram.addr = ptr;
					d.top_item_accum = rd;
					base = (q.ir[2:0] == px_fetch_dec) ? ptr - 8'h01 : ptr;
					if (q.ir[3]) d.ram_pointer_two = base;
					else d.ram_pointer_one = base;
				end else begin
					d.top_item_accum = rd;
					d.expr_stack_ptr = q.expr_stack_ptr - 8'h01;
				end
			end
			st_oper: begin
				case (q.ir[7:4])
					grp_ldptr: begin
						fin = 1'b1;
						case (q.ir[1:0])
							2'h0: d.expr_stack_ptr = q.imm;
							2'h1: d.return_stack_ptr = q.imm;
							2'h2: d.ram_pointer_one = q.imm;
							default: d.ram_pointer_two = q.imm;
						endcase
					end
					grp_table: begin
						ram.addr = q.expr_stack_ptr + 8'h01;
						ram.we = 1'b1;
						d.expr_stack_ptr = q.expr_stack_ptr + 8'h01;
						d.top_item_accum = i_rom_data[7:4];
						d.rdata = {8'h00, i_rom_data[3:0]};
						d.st = st_tail;
					end
					grp_bra, grp_jmp: begin
						if (q.ir[7:4] == grp_jmp ||
							q.flag_nibble[`SCC_FLAG_JUMP]) begin
							d.fetch_counter = {q.ir[3:0], q.imm};
							d.ir = op_nop;
							d.st = st_exec;
						end else begin
							fin = 1'b1;
						end
					end
					default: begin
						d.rdata = q.fetch_counter;
						d.fetch_counter = {q.ir[3:0], q.imm};
						d.ir = op_nop;
						d.idx = 2'h0;
						d.st = st_rpush;
					end
				endcase
			end
			st_rpush: begin
				// Entry takes three nibbles at ptr..ptr+2; ptr+3 is left alone
				base = (q.idx == 2'h0) ?
					q.return_stack_ptr + `SCC_RP_STEP : q.return_stack_ptr;
				ram.addr = base + {6'h00, q.idx};
				ram.we = 1'b1;
				ram.wdata = q.rdata[4'(4'd11 - 4'(q.idx) * 4'd4) -: 4];
				d.return_stack_ptr = base;
				d.idx = q.idx + 2'h1;
				if (q.idx == 2'h2) fin = 1'b1;
			end
			st_rpop: begin
				ram.addr = q.return_stack_ptr + {6'h00, q.idx};
				d.rdata = {q.rdata[7:0], rd};
				d.idx = q.idx + 2'h1;
				if (q.idx == 2'h2) begin
					d.return_stack_ptr = q.return_stack_ptr - `SCC_RP_STEP;
					d.idx = 2'h0;
					if (q.ir == op_from_ret) begin
						d.st = st_tail;
					end else begin
						d.fetch_counter = {q.rdata[7:0], rd};
						d.ir = op_nop;
						d.st = st_exec;
						if (q.ir == op_svc_ret) begin
							d.flag_nibble[`SCC_FLAG_GATE] = 1'b1;
							svc_done = 1'b1;
						end
					end
				end
			end
			st_tail: begin
				ram.addr = q.expr_stack_ptr + 8'h01;
				ram.we = 1'b1;
				d.expr_stack_ptr = q.expr_stack_ptr + 8'h01;
				d.top_item_accum = q.rdata[3:0];
				fin = 1'b1;
			end
		endcase
		if (fin) begin
			// Bank is not stacked on entry; handlers keep it themselves
			if (q.flag_nibble[`SCC_FLAG_GATE] && i_int_req) begin
				int_ack = 1'b1;
				d.rdata = q.fetch_counter;
				d.fetch_counter = {3'h0, i_int_vector, 3'h0};
				d.ir = op_nop;
				d.idx = 2'h0;
				d.st = st_rpush;
			end else begin
				// Prefetched byte becomes the next instruction
				d.ir = i_rom_data;
				d.fetch_counter = q.fetch_counter + 12'h001;
				d.st = st_exec;
				d.idx = 2'h0;
			end
		end
		if (!ce) begin
			d = q;
			d.phase = 1'b1;
			// Writes only on the commit edge, reads settle in phase 0
			ram.we = 1'b0;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q                  <= '0;
			q.st               <= st_exec;
			q.ir               <= op_nop;
			q.fetch_counter    <= `SCC_PC_RST;
			q.rom_bank_select  <= `SCC_BANK_RST;
			q.flag_nibble      <= `SCC_FLAGS_RST;
			q.expr_stack_ptr   <= `SCC_PTR_RST;
			q.return_stack_ptr <= `SCC_PTR_RST;
		end else begin
			q <= d;
		end
	end

	// Table reads borrow the fetch path for one machine cycle
	assign rom_lin = (q.st == st_oper && q.ir[7:4] == grp_table) ?
		{q.ir[3:0], q.imm} : q.fetch_counter;
	assign o_rom_addr = {q.rom_bank_select &&
		(rom_lin > `SCC_COMMON_TOP), rom_lin};
	assign o_io_req = '{addr: io.addr, wdata: io.wdata,
		rd: io.rd && ce, wr: io.wr && ce};
	assign o_int_ack = int_ack && ce;
	assign o_svc_done = svc_done && ce;
	assign o_sleep_req = sleep_req && ce;
	assign o_flag_nibble = q.flag_nibble;
	assign o_top_item_accum = q.top_item_accum;
endmodule : scc_core

/* File: verification/scc_core_props.sv */
// Port-level assertions for the stack core
`timescale 1ns/1ps
module scc_core_props (
	// Clock and reset
	input wire logic                    i_clk,
	input wire logic                    i_sys_rst,
	// Watched outputs
	input wire logic [12:0]             o_rom_addr,
	input wire scc_pkg::scc_io_req_type o_io_req,
	input wire logic                    o_int_ack,
	input wire logic                    o_svc_done,
	input wire logic                    o_sleep_req,
	input wire logic [3:0]              o_flag_nibble,
	input wire logic [3:0]              o_top_item_accum
);
	import scc_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_bank_high;
		o_rom_addr[12] |-> o_rom_addr[11];
	endproperty
	a_bank_high: assert property (p_bank_high)
		else $error("bank bit set below upper half");
	property p_addr_hold;
		$changed(o_rom_addr) |=> $stable(o_rom_addr);
	endproperty
	a_addr_hold: assert property (p_addr_hold)
		else $error("fetch address held under two clocks");
	property p_io_pulse;
		(o_io_req.rd || o_io_req.wr) |=> !(o_io_req.rd || o_io_req.wr);
	endproperty
	a_io_pulse: assert property (p_io_pulse)
		else $error("io strobe longer than one clock");
	property p_bank_port;
		(o_io_req.rd || o_io_req.wr) |-> o_io_req.addr != 4'hd;
	endproperty
	a_bank_port: assert property (p_bank_port)
		else $error("bank port access leaked onto io bus");
	property p_out_data;
		o_io_req.wr |-> o_io_req.wdata == o_top_item_accum;
	endproperty
	a_out_data: assert property (p_out_data)
		else $error("io write data is not the accumulator");
	property p_spare_flag;
		o_flag_nibble[2] == 1'b0;
	endproperty
	a_spare_flag: assert property (p_spare_flag)
		else $error("unused flag bit set");
	property p_ack_gate;
		o_int_ack |-> o_flag_nibble[0];
	endproperty
	a_ack_gate: assert property (p_ack_gate)
		else $error("interrupt taken with gate clear");
	property p_ack_pulse;
		o_int_ack |=> !o_int_ack ##1 !o_int_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("interrupt acknowledge repeated");
	property p_svc_gate;
		(o_svc_done || o_sleep_req) |=> o_flag_nibble[0];
	endproperty
	a_svc_gate: assert property (p_svc_gate)
		else $error("gate not set after return or sleep");
	c_ack: cover property (o_int_ack);
	c_svc: cover property (o_svc_done);
	c_bank: cover property (o_rom_addr[12]);
endmodule : scc_core_props

bind scc_core scc_core_props scc_core_props_inst (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_rom_addr(o_rom_addr),
	.o_io_req(o_io_req), .o_int_ack(o_int_ack), .o_svc_done(o_svc_done),
	.o_sleep_req(o_sleep_req), .o_flag_nibble(o_flag_nibble),
	.o_top_item_accum(o_top_item_accum));

/* File: verification/scc_rom_io_model.sv */
// Program ROM and io peripheral model facing the core
`timescale 1ns/1ps
module scc_rom_io_model (
	// Clock
	input  wire logic                    i_clk,
	// Instruction bus
	input  wire logic [12:0]             i_rom_addr,
	output logic [7:0]                   o_rom_data,
	// Io bus
	input  wire scc_pkg::scc_io_req_type i_io_req,
	output logic [3:0]                   o_io_data
);
	import scc_pkg::*;
	logic [7:0] rom [8192];
	logic [3:0] regs [16];
	logic [7:0] outq [$];
	initial begin
		foreach (regs[k])
			regs[k] = 4'h0;
	end
	// Synchronous read, so data is only valid one clock after the address
	always @(posedge i_clk)
		o_rom_data <= rom[i_rom_addr];
	// Idle bus shows the inverse, never a stale match
	assign o_io_data = i_io_req.rd ? regs[i_io_req.addr] : ~regs[i_io_req.addr];
	always @(posedge i_clk) begin
		if (i_io_req.wr) begin
			regs[i_io_req.addr] <= i_io_req.wdata;
			outq.push_back({i_io_req.addr, i_io_req.wdata});
		end
	end
endmodule : scc_rom_io_model

/* File: verification/testbench.sv */
// Self-checking bench for the stack core
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
	end end
module testbench;
	import scc_pkg::*;
	logic           i_clk;
	logic           i_sys_rst;
	logic [12:0]    rom_addr;
	logic [7:0]     rom_data;
	scc_io_req_type io_req;
	logic [3:0]     io_data;
	logic           int_req;
	logic [5:0]     int_vector;
	logic           int_ack;
	logic           svc_done;
	logic           sleep_req;
	logic [3:0]     flags;
	logic [3:0]     accum;
	int             errors;
	int             num_checks;

	scc_core scc_core_inst (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_rom_addr(rom_addr),
		.i_rom_data(rom_data), .o_io_req(io_req), .i_io_data(io_data),
		.i_int_req(int_req), .i_int_vector(int_vector), .o_int_ack(int_ack),
		.o_svc_done(svc_done), .o_sleep_req(sleep_req),
		.o_flag_nibble(flags), .o_top_item_accum(accum));
	scc_rom_io_model scc_rom_io_model_inst (
		.i_clk(i_clk), .i_rom_addr(rom_addr), .o_rom_data(rom_data),
		.i_io_req(io_req), .o_io_data(io_data));

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	task automatic put(input logic [12:0] a, input logic [7:0] b[$]);
		foreach (b[k])
			scc_rom_io_model_inst.rom[a + 13'(k)] = b[k];
	endtask : put

	// Wipe to no-ops, load, then reset so each program starts clean
	task automatic start(input logic [7:0] b[$]);
		foreach (scc_rom_io_model_inst.rom[k])
			scc_rom_io_model_inst.rom[k] = 8'h00;
		put(13'h000, b);
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		scc_rom_io_model_inst.outq.delete();
		@(negedge i_clk);
		`CHK(flags, 4'h0)
		`CHK(accum, 4'h0)
	endtask : start

	// Each entry is port in the high nibble, value in the low one
	task automatic run_outs(input logic [7:0] exp[$]);
		logic [7:0] got;
		int         n;
		foreach (exp[k]) begin
			n = 0;
			while (scc_rom_io_model_inst.outq.size() == 0 && n < 400) begin
				@(negedge i_clk);
				n++;
			end
			if (scc_rom_io_model_inst.outq.size() == 0) begin
				errors++;
				print_verdict();
			end
			got = scc_rom_io_model_inst.outq.pop_front();
			`CHK(got, exp[k])
		end
	endtask : run_outs

	// Pulse select: 0 acknowledge, 1 service return, 2 sleep
	task automatic wait_pulse(input int which);
		int   n;
		logic p;
		n = 0;
		p = 1'b0;
		while (p !== 1'b1 && n < 300) begin
			p = which == 0 ? int_ack : which == 1 ? svc_done : sleep_req;
			if (p !== 1'b1) begin
				@(negedge i_clk);
				n++;
			end
		end
		`CHK(p, 1'b1)
	endtask : wait_pulse

	// Stack pointers set first, as software must after reset
	task automatic t_alu();
		start('{8'h41, 8'hfc, 8'h40, 8'h10, 8'h23, 8'h25, 8'h01, 8'h61,
			8'h2f, 8'h22, 8'h01, 8'h61, 8'h15, 8'h62, 8'h23, 8'h24,
			8'h04, 8'h15, 8'h62, 8'h25, 8'h23, 8'h06, 8'h15, 8'h62,
			8'h23, 8'h25, 8'h03, 8'h61, 8'h15, 8'h62, 8'hd0, 8'h1e});
		run_outs('{8'h18, 8'h11, 8'h2a, 8'h2a, 8'h28, 8'h1e, 8'h2a});
	endtask : t_alu

	task automatic t_bank();
		start('{8'h41, 8'hfc, 8'h40, 8'h10, 8'h5d, 8'h61, 8'h2f, 8'h6d,
			8'h5d, 8'h61, 8'hd8, 8'h00});
		put(13'h0020, '{8'h23, 8'h65, 8'h20, 8'h6d, 8'hd8, 8'h00});
		put(13'h0800, '{8'h27, 8'h64, 8'hd8, 8'h02});
		put(13'h1800, '{8'h26, 8'h64, 8'hd0, 8'h20});
		run_outs('{8'h10, 8'h14});
		run_outs('{8'h46, 8'h53, 8'h47});
	endtask : t_bank

	task automatic t_ptr();
		start('{8'h41, 8'hfc, 8'h40, 8'h10, 8'h42, 8'h80, 8'h27, 8'h33,
			8'h43, 8'h81, 8'h29, 8'h3b, 8'h30, 8'h61, 8'h38, 8'h61,
			8'h25, 8'h34, 8'h38, 8'h61, 8'h32, 8'h61, 8'h30, 8'h61,
			8'h2c, 8'h19, 8'h1a, 8'h61, 8'hd0, 8'h1c});
		run_outs('{8'h17, 8'h19, 8'h15, 8'h15, 8'h17});
		run_outs('{8'h1c});
	endtask : t_ptr

	task automatic t_branch();
		start('{8'h41, 8'hfc, 8'h40, 8'h10, 8'h23, 8'h24, 8'h06, 8'h09,
			8'hc0, 8'h0c, 8'h21, 8'h61, 8'h12, 8'hc0, 8'h12, 8'h22,
			8'h61, 8'h00, 8'h23, 8'h61, 8'h18, 8'hd0, 8'h15});
		run_outs('{8'h11, 8'h13});
		wait_pulse(2);
		@(negedge i_clk);
		`CHK(flags[0], 1'b1)
	endtask : t_branch

	// Calls, vectors, table, carry chain, flag write and port read
	task automatic t_misc();
		start('{8'h41, 8'hfc, 8'h40, 8'h10, 8'h2f, 8'h14, 8'h15, 8'h61,
			8'h11, 8'h13, 8'h15, 8'h62, 8'h23, 8'h24, 8'h02, 8'h07,
			8'h08, 8'h63, 8'h25, 8'h0a, 8'h01, 8'h61, 8'h53, 8'h64,
			8'he0, 8'h40, 8'h89, 8'hd0, 8'h1b});
		put(13'h0040, '{8'h70, 8'h50, 8'h64, 8'h65, 8'h16});
		put(13'h0048, '{8'h2c, 8'h61, 8'h16});
		put(13'h0050, '{8'h96});
		run_outs('{8'h1b, 8'h28});
		run_outs('{8'h38, 8'h1a});
		run_outs('{8'h48});
		run_outs('{8'h46, 8'h59});
		run_outs('{8'h1c});
	endtask : t_misc

	task automatic t_irq();
		int n;
		@(posedge i_clk);
		int_vector <= 6'h08;
		int_req <= 1'b1;
		start('{8'h41, 8'hfc, 8'h40, 8'h10, 8'hd0, 8'h04});
		put(13'h0040, '{8'h29, 8'h67, 8'h17});
		n = 0;
		repeat (200) begin
			@(negedge i_clk);
			if (int_ack === 1'b1)
				n++;
		end
		`CHK(n, 0)
		start('{8'h41, 8'hfc, 8'h40, 8'h10, 8'h10, 8'hd0, 8'h05});
		// Handler never touches the bank, so nothing to restore
		put(13'h0040, '{8'h29, 8'h67, 8'h17});
		wait_pulse(0);
		@(posedge i_clk);
		int_req <= 1'b0;
		run_outs('{8'h79});
		wait_pulse(1);
		@(negedge i_clk);
		`CHK(flags[0], 1'b1)
	endtask : t_irq

	initial begin
		errors = 0;
		num_checks = 0;
		i_sys_rst = 1'b1;
		int_req = 1'b0;
		int_vector = 6'h00;
		repeat (4) @(posedge i_clk);
		t_alu();
		t_bank();
		t_ptr();
		t_branch();
		t_misc();
		t_irq();
		print_verdict();
	end
endmodule : testbench
